// file: sog_pkg.sv
/*
 * Package of the streaming offset generator: register map, field layout,
 * reset values and carrier structs.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package sog_pkg;
	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int unsigned NUM_GEN = 4;
	localparam int unsigned NUM_LVL = 6;
	localparam int unsigned MAX_ELEM = 64;
	localparam int unsigned LOG_MAX = 3;
	// ------------------------------------------------------------------
	// Register map: generator g occupies GEN_STRIDE bytes from GEN_BASE
	// ------------------------------------------------------------------
	localparam logic [11:0] GEN_BASE = 12'h000;
	localparam logic [11:0] GEN_STRIDE = 12'h080;
	localparam logic [6:0] OFF_LEVEL0_ITERATION_COUNT = 7'h00;
	localparam logic [6:0] OFF_LEVEL_STRIDE = 7'h18;
	localparam logic [6:0] OFF_FLAGS = 7'h2C;
	localparam logic [6:0] OFF_INNER_REMAINING_COUNT = 7'h30;
	localparam logic [6:0] OFF_OFFSET = 7'h48;
	localparam logic [6:0] OFF_PRED_LO = 7'h4C;
	localparam logic [6:0] OFF_PRED_HI = 7'h50;
	localparam logic [6:0] OFF_REMAIN = 7'h54;
	localparam logic [11:0] OFF_CMD = 12'h200;
	localparam logic [11:0] OFF_TASK_STATE = 12'h204;
	// ------------------------------------------------------------------
	// Flag field positions
	// ------------------------------------------------------------------
	localparam int unsigned FLG_VEC_LSB = 0;
	localparam int unsigned FLG_DEC_LSB = 4;
	localparam logic [2:0] VEC_RESERVED = 3'h7;
	localparam logic [2:0] DEC_NORMAL = 3'h0;
	localparam logic [2:0] DEC_MAX = 3'h5;
	// Command register bits
	localparam int unsigned CMD_OPEN_LSB = 0;
	localparam int unsigned CMD_CLOSE_LSB = 4;
	localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] APB_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic [1:0] gen;
		logic advance;
		logic scalar_pred;
		logic is_store;
		logic is_vector;
		logic [1:0] esize;
		logic [6:0] nelem;
		logic [63:0] base;
	} sog_req_t;

	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic [63:0] byte_en;
	} sog_mem_t;
endpackage

// file: sog_top.sv
/*
 * Streaming offset generator: four generators each walking a six-level
 * loop nest, producing offsets, store predicates and byte enables.
 * Assumes the load/store issue logic presents up to two accesses a cycle
 * and that software writes configuration only while a stream is closed.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Address equals selected base plus generator offset.
// - Innermost level steps contiguous elements upward, stride one.
// - Opening a forward stream starts offset at zero.
// - Completing level one to five sets offset to saved start plus stride.
// - Inner step adds element count; mask is full or remaining low ones.
// - Outer strides count elements between consecutive iteration starts.
// - Strip mining uses level-zero count as initial frame width.
// - Each of four generators holds remaining-element store predicate.
// - Streaming stores use generator predicate, turned into byte enables.
// - Predicates regenerate on open and on each advancing access.
// - Predicate covers next element count, power of two one to 64.
// - Predicate bits sit in the low bits of the register.
// - Final loop predicate from remaining minus count, saturating at zero.
// - Inner count reloads when strip dimension or higher reloads.
// - Byte enables follow element size; packing follows store data.
// - Store uses low bits only; beyond remaining count are zero.
// - Advance only when scalar predicate is true.
// - Two same-cycle advances on one generator advance once.
// - Scalar streaming stores may also use the store predicate.
// - Interrupt, exception or call clears stream-active bits.
// - Generator configuration and counts survive such events.
// - Return restores task state and reactivates prior streams.
// - Open loads every level count from its configured count.
// - Past last offset, generator returns zero offsets.
// - Element count codes 0..6 mean 1..64; code 7 reserved.
module sog_top #(
	parameter int unsigned CNT_W = 32
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Issue ports
	input wire sog_pkg::sog_req_t req_a,
	input wire sog_pkg::sog_req_t req_b,
	// Task events
	input wire logic event_enter,
	input wire logic event_return,
	// Level-one data memory side
	output sog_pkg::sog_mem_t mem_a,
	output sog_pkg::sog_mem_t mem_b,
	output logic [3:0] stream_active
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [CNT_W-1:0] icnt_q [sog_pkg::NUM_GEN][sog_pkg::NUM_LVL];
	logic [CNT_W-1:0] cnt_q [sog_pkg::NUM_GEN][sog_pkg::NUM_LVL];
	logic [31:0] stride_q [sog_pkg::NUM_GEN][sog_pkg::NUM_LVL];
	logic [31:0] start_q [sog_pkg::NUM_GEN][sog_pkg::NUM_LVL];
	logic [31:0] flags_q [sog_pkg::NUM_GEN];
	logic [31:0] offset_q [sog_pkg::NUM_GEN];
	logic [63:0] pred_q [sog_pkg::NUM_GEN];
	logic [3:0] done_q;
	logic [3:0] active_q;
	logic [3:0] saved_active_q;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic wr_en;
	logic rd_en;
	logic gen_hit;
	logic [1:0] agen;
	logic [6:0] aoff;
	logic [2:0] alvl;
	logic [3:0] open_req;
	logic [3:0] close_req;
	logic [3:0] adv;

	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign gen_hit = (paddr < sog_pkg::GEN_STRIDE * 4) && (paddr[1:0] == 2'h0);
	assign agen = paddr[8:7];
	assign aoff = paddr[6:0];
	assign alvl = 3'(aoff[6:2] % 5'd6);

	// ------------------------------------------------------------------
	// Element count and mask helpers
	// ------------------------------------------------------------------
	function automatic logic [6:0] vec_count(input logic [2:0] code);
		vec_count = 7'(1) << code;
	endfunction

	// Predicate mask of the low n bits, n saturating at MAX_ELEM
	function automatic logic [63:0] low_mask(input logic [CNT_W-1:0] n);
		logic [63:0] m;
		m = 64'h0;
		for (int i = 0; i < 64; i++) begin
			m[i] = (CNT_W'(i) < n);
		end
		low_mask = m;
	endfunction

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	always_comb begin
		open_req = 4'h0;
		close_req = 4'h0;
		if (wr_en && paddr == sog_pkg::OFF_CMD) begin
			open_req = pwdata[sog_pkg::CMD_OPEN_LSB +: 4];
			close_req = pwdata[sog_pkg::CMD_CLOSE_LSB +: 4];
		end
	end

	// ------------------------------------------------------------------
	// Bus error response
	// ------------------------------------------------------------------
	// Reserved size code on open, a write to an open generator's config, or an address outside the generator windows, OFF_CMD and OFF_TASK_STATE is an error
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			if (gen_hit) begin
				pslverr = wr_en && active_q[agen];
			end else if (paddr == sog_pkg::OFF_CMD) begin
				for (int g = 0; g < 4; g++) begin
					if (open_req[g] && flags_q[g][sog_pkg::FLG_VEC_LSB +: 3]
						== sog_pkg::VEC_RESERVED) begin
						pslverr = 1'b1;
					end
				end
			end else if (paddr != sog_pkg::OFF_TASK_STATE) begin
				pslverr = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	always_comb begin
		prdata = sog_pkg::APB_ZERO;
		if (rd_en && gen_hit) begin
			if (aoff < sog_pkg::OFF_LEVEL_STRIDE) begin
				prdata = 32'(icnt_q[agen][alvl]);
			end else if (aoff < sog_pkg::OFF_FLAGS) begin
				prdata = stride_q[agen][3'(aoff[6:2] - 5'd5)];
			end else if (aoff == sog_pkg::OFF_FLAGS) begin
				prdata = flags_q[agen];
			end else if (aoff < sog_pkg::OFF_OFFSET) begin
				prdata = 32'(cnt_q[agen][3'(aoff[6:2] - 5'd12)]);
			end else if (aoff == sog_pkg::OFF_OFFSET) begin
				prdata = done_q[agen] ? 32'h0 : offset_q[agen];
			end else if (aoff == sog_pkg::OFF_PRED_LO) begin
				prdata = pred_q[agen][31:0];
			end else if (aoff == sog_pkg::OFF_PRED_HI) begin
				prdata = pred_q[agen][63:32];
			end else if (aoff == sog_pkg::OFF_REMAIN) begin
				prdata = 32'(cnt_q[agen][0]);
			end
		end else if (rd_en && paddr == sog_pkg::OFF_TASK_STATE) begin
			prdata = {24'h0, saved_active_q, active_q};
		end
	end

	// ------------------------------------------------------------------
	// Advance requests: one step per generator per cycle
	// ------------------------------------------------------------------
	always_comb begin
		adv = 4'h0;
		for (int g = 0; g < 4; g++) begin
			if (req_a.valid && req_a.advance && req_a.scalar_pred && req_a.gen == 2'(g)) begin
				adv[g] = active_q[g];
			end
			if (req_b.valid && req_b.advance && req_b.scalar_pred && req_b.gen == 2'(g)) begin
				adv[g] = active_q[g];
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration writes and loop-nest walk
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int g = 0; g < 4; g++) begin
				flags_q[g] <= sog_pkg::FLAGS_RST;
				offset_q[g] <= 32'h0;
				pred_q[g] <= 64'h0;
				for (int l = 0; l < 6; l++) begin
					icnt_q[g][l] <= '0;
					cnt_q[g][l] <= '0;
					stride_q[g][l] <= 32'h0;
					start_q[g][l] <= 32'h0;
				end
			end
			done_q <= 4'h0;
		end else begin
			if (wr_en && gen_hit && !active_q[agen]) begin
				if (aoff < sog_pkg::OFF_LEVEL_STRIDE) begin
					icnt_q[agen][alvl] <= CNT_W'(pwdata);
				end else if (aoff < sog_pkg::OFF_FLAGS) begin
					stride_q[agen][3'(aoff[6:2] - 5'd5)] <= pwdata;
				end else if (aoff == sog_pkg::OFF_FLAGS) begin
					flags_q[agen] <= pwdata;
				end
			end
			for (int g = 0; g < 4; g++) begin
				logic [2:0] dec;
				logic [6:0] vl;
				logic wrap;
				logic [31:0] nxt;
				dec = flags_q[g][sog_pkg::FLG_DEC_LSB +: 3];
				vl = vec_count(flags_q[g][sog_pkg::FLG_VEC_LSB +: 3]);
				wrap = 1'b1;
				nxt = offset_q[g];
				// Task events win over open, so the walk state must not restart either
				if (open_req[g] && !active_q[g] && !event_enter && !event_return
					&& flags_q[g][sog_pkg::FLG_VEC_LSB +: 3] != sog_pkg::VEC_RESERVED) begin
					offset_q[g] <= 32'h0;
					done_q[g] <= 1'b0;
					for (int l = 0; l < 6; l++) begin
						cnt_q[g][l] <= icnt_q[g][l];
						start_q[g][l] <= 32'h0;
					end
					pred_q[g] <= low_mask(icnt_q[g][0] < CNT_W'(vl) ?
						icnt_q[g][0] : CNT_W'(vl));
				end else if (adv[g] && !done_q[g]) begin
					nxt = offset_q[g] + 32'(vl);
					if (cnt_q[g][0] > CNT_W'(vl)) begin
						cnt_q[g][0] <= cnt_q[g][0] - CNT_W'(vl);
						wrap = 1'b0;
					end else begin
						cnt_q[g][0] <= '0;
					end
					for (int l = 1; l < 6; l++) begin
						if (wrap) begin
							if (cnt_q[g][l] > CNT_W'(1)) begin
								cnt_q[g][l] <= cnt_q[g][l] - CNT_W'(1);
								nxt = start_q[g][l] + stride_q[g][l];
								for (int k = 1; k < l; k++) begin
									cnt_q[g][k] <= icnt_q[g][k];
									start_q[g][k] <= nxt;
								end
								if (dec == sog_pkg::DEC_NORMAL || 3'(l) >= dec) begin
									cnt_q[g][0] <= icnt_q[g][0];
								end
								start_q[g][l] <= nxt;
								wrap = 1'b0;
							end else begin
								cnt_q[g][l] <= '0;
							end
						end
					end
					if (wrap) begin
						done_q[g] <= 1'b1;
						offset_q[g] <= 32'h0;
						pred_q[g] <= 64'h0;
					end else begin
						offset_q[g] <= nxt;
						if (cnt_q[g][0] > CNT_W'(vl)) begin
							pred_q[g] <= low_mask(cnt_q[g][0] - CNT_W'(vl));
						end else begin
							pred_q[g] <= low_mask(icnt_q[g][0] < CNT_W'(vl) ?
								icnt_q[g][0] : CNT_W'(vl));
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Stream-active bits and task-state save
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= 4'h0;
			saved_active_q <= 4'h0;
		end else if (event_enter) begin
			saved_active_q <= active_q;
			active_q <= 4'h0;
		end else if (event_return) begin
			active_q <= saved_active_q;
		end else begin
			for (int g = 0; g < 4; g++) begin
				if (close_req[g]) begin
					active_q[g] <= 1'b0;
				end else if (open_req[g] && flags_q[g][sog_pkg::FLG_VEC_LSB +: 3]
					!= sog_pkg::VEC_RESERVED) begin
					active_q[g] <= 1'b1;
				end
			end
		end
	end

	assign stream_active = active_q;

	// ------------------------------------------------------------------
	// Address and byte enables to data memory
	// ------------------------------------------------------------------
	function automatic sog_pkg::sog_mem_t build(input sog_pkg::sog_req_t r,
		input logic [31:0] off, input logic [63:0] pred);
		sog_pkg::sog_mem_t m;
		logic [63:0] p;
		int unsigned bytes;
		m.valid = r.valid;
		m.addr = r.base + 64'(off);
		p = pred & low_mask(CNT_W'(r.is_vector ? r.nelem : 7'd1));
		bytes = 1 << r.esize;
		m.byte_en = 64'h0;
		for (int b = 0; b < 64; b++) begin
			m.byte_en[b] = r.is_store && p[b / bytes];
		end
		build = m;
	endfunction

	// ------------------------------------------------------------------
	// Registered memory outputs
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_a <= '0;
			mem_b <= '0;
		end else begin
			mem_a <= build(req_a, done_q[req_a.gen] ? 32'h0 : offset_q[req_a.gen],
				pred_q[req_a.gen]);
			mem_b <= build(req_b, done_q[req_b.gen] ? 32'h0 : offset_q[req_b.gen],
				pred_q[req_b.gen]);
		end
	end
endmodule

// file: sog_top_asserts.sv
/* Port checker of the streaming offset generator.
   Assumes it is bound onto sog_top. */
`timescale 1ns/1ps
module sog_chk (
	// Clock and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// Issue, events, memory
	input wire sog_pkg::sog_req_t req_a,
	input wire sog_pkg::sog_req_t req_b,
	input wire logic event_enter,
	input wire logic event_return,
	input wire sog_pkg::sog_mem_t mem_a,
	input wire sog_pkg::sog_mem_t mem_b,
	input wire logic [3:0] stream_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic cmd_wr;
	logic vst;
	assign cmd_wr = psel && penable && pwrite && paddr == sog_pkg::OFF_CMD;
	assign vst = req_a.valid && req_a.is_store && req_a.is_vector;
	sequence s_enter_return;
		event_enter && !event_return ##1 event_return && !event_enter;
	endsequence
	sequence s_held_issue;
		req_a.valid && !req_a.scalar_pred && !req_b.valid && !event_enter && !cmd_wr;
	endsequence
	a_mem_follows: assert property (
		req_a.valid |=> mem_a.valid) else $error("no memory access after issue");
	a_load_no_enable: assert property (
		req_a.valid && !req_a.is_store |=> mem_a.byte_en == 64'h0) else $error("load enables");
	a_dual_same_offset: assert property (
		req_a.valid && req_b.valid && req_a.gen == req_b.gen
		|=> mem_a.addr - $past(req_a.base) == mem_b.addr - $past(req_b.base))
		else $error("dual issue offsets differ");
	a_enter_clears: assert property (
		event_enter && !event_return |=> stream_active == 4'h0) else $error("active kept");
	a_return_restores: assert property (
		s_enter_return |=> stream_active == $past(stream_active, 2)) else $error("not restored");
	a_open_activates: assert property (
		cmd_wr && !pslverr && pwdata[7:4] == 4'h0 && !event_enter && !event_return
		|=> (stream_active & $past(pwdata[3:0])) == $past(pwdata[3:0])) else $error("not opened");
	a_bad_open_keeps: assert property (
		cmd_wr && pslverr && !event_enter && !event_return |=> $stable(stream_active))
		else $error("refused command changed state");
	a_no_pred_hold: assert property (
		s_held_issue ##1 (req_a.valid && !req_b.valid && $stable(req_a.gen) && $stable(req_a.base))
		|=> $stable(mem_a.addr)) else $error("advanced without predicate");
	a_enable_bound: assert property (
		vst |=> (mem_a.byte_en >> ({3'h0, $past(req_a.nelem)} << $past(req_a.esize))) == 64'h0)
		else $error("enables beyond element count");
	a_enable_low_fill: assert property (
		vst |=> ((mem_a.byte_en + 64'h1) & mem_a.byte_en) == 64'h0) else $error("enables not low");
endmodule
bind sog_top sog_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .req_a(req_a),
	.req_b(req_b), .event_enter(event_enter), .event_return(event_return), .mem_a(mem_a),
	.mem_b(mem_b), .stream_active(stream_active));

// file: sog_core_model.sv
/* Model of the load/store issue logic driving both issue ports.
   Assumes the caller waits for its task to return. */
`timescale 1ns/1ps
module sog_core_model (
	// Clock
	input wire logic pclk,
	// Issue ports
	output sog_pkg::sog_req_t req_a,
	output sog_pkg::sog_req_t req_b
);
	initial begin
		req_a = '0;
		req_b = '0;
	end
	// Hold a pair for n edges, then go idle
	task automatic issue(input sog_pkg::sog_req_t a, input sog_pkg::sog_req_t b, input int n);
		@(posedge pclk);
		req_a <= a;
		req_b <= b;
		repeat (n) @(posedge pclk);
		req_a <= '0;
		req_b <= '0;
	endtask
endmodule

// file: testbench.sv
/* Self-checking bench of the streaming offset generator.
   Assumes sog_top, sog_chk and sog_core_model are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, event_enter, event_return, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] stream_active;
	sog_pkg::sog_req_t req_a, req_b;
	sog_pkg::sog_mem_t mem_a, mem_b;
	int error_cnt = 0;
	int num_checks = 0;
	logic [63:0] ea [4] = '{64'h1004, 64'h1010, 64'h1014, 64'h1000};
	logic [63:0] eb [4] = '{64'hF, 64'hFF, 64'hF, 64'h0};
	logic [6:0] ne [4] = '{7'h10, 7'h02, 7'h10, 7'h10};
	logic [6:0] ra [4] = '{sog_pkg::OFF_OFFSET, sog_pkg::OFF_PRED_LO, sog_pkg::OFF_INNER_REMAINING_COUNT,
		sog_pkg::OFF_REMAIN};
	logic [31:0] rx [4] = '{32'h0, 32'hF, 32'h5, 32'h5};
	sog_top #(.CNT_W(32)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req_a(req_a), .req_b(req_b),
		.event_enter(event_enter), .event_return(event_return), .mem_a(mem_a), .mem_b(mem_b),
		.stream_active(stream_active));
	sog_core_model u_core (.pclk(pclk), .req_a(req_a), .req_b(req_b));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic sog_pkg::sog_req_t mk(input logic sp, input logic st, input logic [6:0] n,
		input logic [63:0] b);
		mk = '{valid: 1'b1, gen: 2'h0, advance: 1'b1, scalar_pred: sp, is_store: st,
			is_vector: 1'b1, esize: 2'h2, nelem: n, base: b};
	endfunction
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) error_cnt++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic pulse(input logic ent);
		@(posedge pclk);
		event_enter <= ent;
		event_return <= !ent;
		@(posedge pclk);
		event_enter <= 1'b0;
		event_return <= 1'b0;
		#1;
	endtask
	task automatic chk_mem(input logic [63:0] a, input logic [63:0] b);
		#1;
		`CHK("address", a, mem_a.addr)
		`CHK("byte enables", b, mem_a.byte_en)
	endtask
	task automatic t_reset;
		apb(1'b0, {5'h0, sog_pkg::OFF_FLAGS}, 32'h0);
		`CHK("flags reset", sog_pkg::FLAGS_RST, rd)
		apb(1'b0, 12'h300, 32'h0);
		`CHK("unmapped error", 1'b1, err)
	endtask
	task automatic t_open;
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, 12'(k * 4), (k == 0) ? 32'h5 : (k == 1) ? 32'h2 : 32'h1);
		end
		apb(1'b1, {5'h0, sog_pkg::OFF_LEVEL_STRIDE}, 32'h10);
		apb(1'b1, {5'h0, sog_pkg::OFF_FLAGS}, 32'h2);
		apb(1'b1, sog_pkg::OFF_CMD, 32'h1);
		`CHK("active", 4'h1, stream_active)
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, {5'h0, ra[k]}, 32'h0);
			`CHK("state read", rx[k], rd)
		end
	endtask
	task automatic t_issue;
		u_core.issue(mk(1'b0, 1'b0, 7'h10, 64'h1000), '0, 2);
		chk_mem(64'h1000, 64'h0);
		u_core.issue(mk(1'b1, 1'b1, 7'h10, 64'h1000), mk(1'b1, 1'b1, 7'h10, 64'h2000), 1);
		chk_mem(64'h1000, 64'hFFFF);
		`CHK("second port", 64'h2000, mem_b.addr)
		`CHK("second enables", 64'hFFFF, mem_b.byte_en)
		pulse(1'b1);
		`CHK("active", 4'h0, stream_active)
		apb(1'b0, {5'h0, sog_pkg::OFF_OFFSET}, 32'h0);
		`CHK("kept offset", 32'h4, rd)
		pulse(1'b0);
		`CHK("active", 4'h1, stream_active)
		for (int i = 0; i < 4; i++) begin
			u_core.issue(mk(1'b1, 1'b1, ne[i], 64'h1000), '0, 1);
			chk_mem(ea[i], eb[i]);
		end
	endtask
	task automatic t_refuse;
		apb(1'b1, {5'h0, sog_pkg::OFF_FLAGS}, 32'h2);
		`CHK("write while open", 1'b1, err)
		apb(1'b1, 12'h0AC, 32'h7);
		apb(1'b1, sog_pkg::OFF_CMD, 32'h2);
		`CHK("reserved open", 1'b1, err)
		`CHK("active", 4'h1, stream_active)
		apb(1'b1, sog_pkg::OFF_CMD, 32'h10);
		`CHK("closed", 4'h0, stream_active)
		apb(1'b1, sog_pkg::OFF_CMD, 32'h1);
		apb(1'b0, {5'h0, sog_pkg::OFF_PRED_LO}, 32'h0);
		`CHK("reopen predicate", 32'hF, rd)
		apb(1'b0, {5'h0, sog_pkg::OFF_OFFSET}, 32'h0);
		`CHK("reopen offset", 32'h0, rd)
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, event_enter, event_return, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_open;
		t_issue;
		t_refuse;
		finish_test;
	end
	initial begin
		#1000000;
		error_cnt++;
		finish_test;
	end
endmodule
